//--- logic/sti_pkg.sv
// Purpose: Shared constants and carriers for the status bit inserter
// Assumes: 32-bit AXI4-Lite register bus, byte address is four times index
// Notes: Register reset values encode the channel-status defaults
package sti_pkg;
  // Register indices, byte address is index times four
  localparam logic [7:0] IDX_CTRL = 8'h1E;
  localparam logic [7:0] IDX_CS1 = 8'h1F;
  localparam logic [7:0] IDX_CAT = 8'h20;
  localparam logic [7:0] IDX_SRC = 8'h21;
  localparam logic [7:0] IDX_RATE = 8'h22;
  localparam logic [7:0] IDX_WLEN = 8'h23;
  localparam logic [7:0] IDX_STAT = 8'h24;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_CS1 = 8'h00;
  localparam logic [7:0] RST_CAT = 8'h00;
  localparam logic [7:0] RST_SRC = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h31;
  localparam logic [7:0] RST_WLEN = 8'h0B;
  // Writable bit masks, reserved bits read zero
  localparam logic [7:0] MSK_CTRL = 8'h07;
  localparam logic [7:0] MSK_RATE = 8'h3F;
  // Control fields
  localparam int CTRL_OVW = 2;
  localparam logic [1:0] SRC_RECEIVER = 2'h0;
  // Block geometry and bus response codes
  localparam logic [7:0] BLOCK_LAST = 8'hBF;
  localparam logic [7:0] CS_USED = 8'h28;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One sub-frame request from the framer
  typedef struct packed {
    logic strobe;
    logic second;
    logic blockStart;
    logic [23:0] audio;
  } sti_sub_s;

  // Bits recovered by the receiver for the same sub-frame
  typedef struct packed {
    logic valid;
    logic user;
    logic status;
  } sti_rx_s;

  // Inserted bits toward the framer
  typedef struct packed {
    logic strobe;
    logic valid;
    logic user;
    logic status;
    logic parity;
  } sti_bits_s;
endpackage : sti_pkg

//--- logic/sti_status_insert.sv
// Purpose: Validity, user, channel-status and parity bit insertion
// Assumes: One sub-frame strobe at most per cycle, inputs synchronous to clk
// Notes: Five channel-status registers plus control and status over AXI
`timescale 1ns/1ps
`default_nettype none
module sti_status_insert (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sub-frame request and recovered bits
  input wire sti_pkg::sti_sub_s subIn,
  input wire sti_pkg::sti_rx_s rxBits,
  // Inserted bits toward the framer
  output sti_pkg::sti_bits_s bitsOut
);
  import sti_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cs1;
    logic [7:0] cat;
    logic [7:0] srcCh;
    logic [7:0] rate;
    logic [7:0] wlen;
    logic [7:0] frameIdx;
    logic awHeld;
    logic [7:0] awIdx;
    logic awBad;
    logic wHeld;
    logic [7:0] wByte;
    logic wEn;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    sti_bits_s bits;
  } sti_state_s;

  sti_state_s st_q;
  sti_state_s st_d;

  // Register index of a byte address; upper or misaligned bits mark it bad
  // Only byte lane zero carries data; the upper lanes are ignored
  function automatic logic [7:0] regIdx(input logic [31:0] addr);
    regIdx = addr[9:2];
  endfunction : regIdx

  function automatic logic badAddr(input logic [31:0] addr);
    badAddr = (addr[31:10] != 22'h000000) || (addr[1:0] != 2'h0);
  endfunction : badAddr

  // Channel id field to status bits 23:20
  function automatic logic [3:0] chanMap(input logic [1:0] id);
    case (id)
      2'h1: chanMap = 4'h1;
      2'h2: chanMap = 4'h2;
      default: chanMap = 4'h0;
    endcase
  endfunction : chanMap

  // Forty configured status bits for one sub-frame position
  // Bits 31:30 are sent as zero; no register field programs them
  function automatic logic [39:0] csVector(input sti_state_s s,
                                           input logic second);
    logic [1:0] id;
    id = second ? s.srcCh[7:6] : s.srcCh[5:4];
    csVector = {s.wlen[7:4], // original rate, bits 39:36
                s.wlen[3:1],
                s.wlen[0],
                2'h0,
                s.rate[5:4],
                s.rate[3:0],
                chanMap(id),
                s.srcCh[3:0],
                s.cat,
                s.cs1[7:6],
                s.cs1[5:3],
                s.cs1[2],
                s.cs1[1],
                s.cs1[0]};
  endfunction : csVector

  // Status register readback image for an index
  // Unmapped indices read zero; the bus answer already flags the error
  function automatic logic [7:0] readReg(input sti_state_s s,
                                         input logic [7:0] idx);
    case (idx)
      IDX_CTRL: readReg = s.ctrl;
      IDX_CS1: readReg = s.cs1;
      IDX_CAT: readReg = s.cat;
      IDX_SRC: readReg = s.srcCh;
      IDX_RATE: readReg = s.rate;
      IDX_WLEN: readReg = s.wlen;
      IDX_STAT: readReg = s.frameIdx;
      default: readReg = 8'h00;
    endcase
  endfunction : readReg

  // Mapped window runs from the control index up to the status index
  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx >= IDX_CTRL) && (idx <= IDX_STAT);
  endfunction : mapped

  // Handshake readies straight from held state
  // A pending response blocks new writes, so one write is under way at most
  assign s_axi_awready = !st_q.awHeld && !st_q.bValid;
  assign s_axi_wready = !st_q.wHeld && !st_q.bValid;
  assign s_axi_arready = !st_q.rValid;
  assign s_axi_bvalid = st_q.bValid;
  assign s_axi_bresp = st_q.bResp;
  assign s_axi_rvalid = st_q.rValid;
  assign s_axi_rresp = st_q.rResp;
  assign s_axi_rdata = st_q.rData;
  assign bitsOut = st_q.bits;

  // Next state: bus slave, frame tracking and bit insertion
  always_comb begin
    logic [7:0] idx;
    logic [39:0] cs;
    logic csBit;
    logic fromRx;
    idx = 8'h00;
    cs = 40'h0;
    csBit = 1'b0;
    fromRx = 1'b0;
    st_d = st_q;
    st_d.bits.strobe = 1'b0;

    // Address and data are captured independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.awHeld = 1'b1;
      st_d.awIdx = regIdx(s_axi_awaddr);
      st_d.awBad = badAddr(s_axi_awaddr) || !mapped(regIdx(s_axi_awaddr));
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.wHeld = 1'b1;
      st_d.wByte = s_axi_wdata[7:0];
      st_d.wEn = s_axi_wstrb[0];
    end
    // Commit once both halves are held; the status index is read-only
    // A cleared lane-zero strobe still answers OKAY but changes nothing
    if (st_q.awHeld && st_q.wHeld) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = st_q.awBad ? RESP_SLVERR : RESP_OKAY;
      if (!st_q.awBad && st_q.wEn) begin
        case (st_q.awIdx)
          IDX_CTRL: st_d.ctrl = st_q.wByte & MSK_CTRL;
          IDX_CS1: st_d.cs1 = st_q.wByte;
          IDX_CAT: st_d.cat = st_q.wByte;
          IDX_SRC: st_d.srcCh = st_q.wByte;
          IDX_RATE: st_d.rate = st_q.wByte & MSK_RATE;
          IDX_WLEN: st_d.wlen = st_q.wByte;
          default: st_d.ctrl = st_q.ctrl;
        endcase
      end
    end
    if (st_q.bValid && s_axi_bready) begin
      st_d.bValid = 1'b0;
    end

    // Reads answer one cycle after the address is taken
    if (st_q.rValid && s_axi_rready) begin
      st_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      idx = regIdx(s_axi_araddr);
      st_d.rValid = 1'b1;
      if (badAddr(s_axi_araddr) || !mapped(idx)) begin
        st_d.rResp = RESP_SLVERR;
        st_d.rData = 32'h00000000;
      end else begin
        st_d.rResp = RESP_OKAY;
        st_d.rData = {24'h000000, readReg(st_q, idx)};
      end
    end

    // Sub-frame insertion; a block start forces frame index zero
    if (subIn.strobe) begin
      idx = subIn.blockStart ? 8'h00 : st_q.frameIdx;
      cs = csVector(st_q, subIn.second);
      csBit = (idx < CS_USED) ? cs[idx[5:0]] : 1'b0;
      // Every source code other than the receiver means locally built bits
      fromRx = (st_q.ctrl[1:0] == SRC_RECEIVER);
      st_d.bits.strobe = 1'b1;
      st_d.bits.valid = fromRx ? rxBits.valid : 1'b0;
      st_d.bits.user = fromRx ? rxBits.user : 1'b0;
      st_d.bits.status = (fromRx && !st_q.ctrl[CTRL_OVW]) ?
                         rxBits.status : csBit;
      // Parity is taken over the bits just chosen, so the value sent always
      // matches the bits that leave with the same strobe
      st_d.bits.parity = ^{subIn.audio, st_d.bits.valid, st_d.bits.user,
                           st_d.bits.status};
      // Frame count advances after the second sub-frame only
      // The block length is fixed; a late block start just restarts the count
      if (subIn.second) begin
        st_d.frameIdx = (idx == BLOCK_LAST) ? 8'h00 : idx + 8'h01;
      end else begin
        st_d.frameIdx = idx;
      end
    end
  end

  // State register with synchronous reset
  // Register defaults come from the package so reads after reset match
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.ctrl <= RST_CTRL;
      st_q.cs1 <= RST_CS1;
      st_q.cat <= RST_CAT;
      st_q.srcCh <= RST_SRC;
      st_q.rate <= RST_RATE;
      st_q.wlen <= RST_WLEN;
    end else begin
      st_q <= st_d;
    end
  end

  // Checks on the inserted bits, frame index, reset values and bus answers
  validity_zero_a: assert property (@(posedge clk) disable iff (rst)
    bitsOut.strobe && ($past(st_q.ctrl[1:0]) != SRC_RECEIVER)
    |-> !bitsOut.valid) else $error("validity not zero");
  user_zero_a: assert property (@(posedge clk) disable iff (rst)
    bitsOut.strobe && ($past(st_q.ctrl[1:0]) != SRC_RECEIVER)
    |-> !bitsOut.user) else $error("user bit not zero");
  even_parity_a: assert property (@(posedge clk) disable iff (rst)
    bitsOut.strobe |-> (^{$past(subIn.audio), bitsOut.valid, bitsOut.user,
    bitsOut.status, bitsOut.parity}) == 1'b0)
    else $error("parity not even");
  status_pass_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && (st_q.ctrl[1:0] == SRC_RECEIVER) && !st_q.ctrl[CTRL_OVW]
    |=> bitsOut.status == $past(rxBits.status))
    else $error("status not forwarded");
  tail_zero_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && !subIn.blockStart && (st_q.frameIdx >= CS_USED) &&
    (st_q.ctrl[1:0] != SRC_RECEIVER) |=> !bitsOut.status)
    else $error("status beyond bit 39 set");
  frame_wrap_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && subIn.second && !subIn.blockStart &&
    (st_q.frameIdx == BLOCK_LAST) |=> st_q.frameIdx == 8'h00)
    else $error("frame index did not wrap");
  frame_range_a: assert property (@(posedge clk) disable iff (rst)
    st_q.frameIdx <= BLOCK_LAST) else $error("frame index out of range");
  rate_reset_a: assert property (@(posedge clk)
    rst |=> (st_q.rate == RST_RATE) && (st_q.wlen == RST_WLEN))
    else $error("status reset values wrong");
  left_id_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && !subIn.second && !subIn.blockStart &&
    (st_q.frameIdx == 8'h14) && (st_q.srcCh[5:4] == 2'h1) &&
    st_q.ctrl[CTRL_OVW] |=> bitsOut.status)
    else $error("left channel id not sent");
  read_answer_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_hold_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  // Bus and link checks below watch only what this block drives
  // Reset leaves the bus idle with every ready raised
  ready_reset_a: assert property (@(posedge clk)
    rst |=> s_axi_awready && s_axi_wready && s_axi_arready &&
    !s_axi_bvalid && !s_axi_rvalid) else $error("bus not idle after reset");
  // Reset clears the line bits so no stale strobe reaches the framer
  bits_reset_a: assert property (@(posedge clk)
    rst |=> bitsOut == '0) else $error("line bits not cleared");
  // Each request gives one answer strobe exactly one cycle later
  strobe_answer_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe |=> bitsOut.strobe)
    else $error("answer strobe missing");
  // No request, no answer strobe
  strobe_idle_a: assert property (@(posedge clk) disable iff (rst)
    !subIn.strobe |=> !bitsOut.strobe)
    else $error("answer strobe without request");
  // Bit values stand until the next request
  bits_hold_a: assert property (@(posedge clk) disable iff (rst)
    !subIn.strobe |=> $stable({bitsOut.valid, bitsOut.user,
    bitsOut.status, bitsOut.parity}))
    else $error("line bits changed without request");
  // Receiver source forwards the recovered validity
  rx_valid_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && (st_q.ctrl[1:0] == SRC_RECEIVER)
    |=> bitsOut.valid == $past(rxBits.valid)) else $error("validity lost");
  // Receiver source forwards the recovered user bit
  rx_user_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && (st_q.ctrl[1:0] == SRC_RECEIVER)
    |=> bitsOut.user == $past(rxBits.user)) else $error("user bit lost");
  // With overwrite, frame zero carries the consumer flag from the register
  consumer_bit_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && subIn.blockStart && !subIn.second &&
    st_q.ctrl[CTRL_OVW] |=> bitsOut.status == $past(st_q.cs1[0]))
    else $error("consumer flag not sent");
  // Frame index steps by one after the second sub-frame
  frame_step_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && subIn.second && !subIn.blockStart &&
    (st_q.frameIdx != BLOCK_LAST)
    |=> st_q.frameIdx == $past(st_q.frameIdx) + 8'h01)
    else $error("frame index did not step");
  // A first sub-frame without a block start never moves the index
  frame_keep_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && !subIn.second && !subIn.blockStart
    |=> $stable(st_q.frameIdx)) else $error("frame index moved early");
  // A block start restarts the count at zero
  frame_start_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && subIn.blockStart && !subIn.second
    |=> st_q.frameIdx == 8'h00) else $error("block start ignored");
  // Right mark on the second sub-frame sets status bit 21
  right_id_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && subIn.second && !subIn.blockStart &&
    (st_q.frameIdx == 8'h15) && (st_q.srcCh[7:6] == 2'h2) &&
    st_q.ctrl[CTRL_OVW] |=> bitsOut.status)
    else $error("right channel id not sent");
  // Left mark on the first sub-frame keeps status bit 21 low
  left_clear_a: assert property (@(posedge clk) disable iff (rst)
    subIn.strobe && !subIn.second && !subIn.blockStart &&
    (st_q.frameIdx == 8'h15) && (st_q.srcCh[5:4] == 2'h1) &&
    st_q.ctrl[CTRL_OVW] |=> !bitsOut.status)
    else $error("left channel id wrong");
  // Reserved control and rate bits always hold zero
  ctrl_mask_a: assert property (@(posedge clk) disable iff (rst)
    ((st_q.ctrl & ~MSK_CTRL) == 8'h00) && ((st_q.rate & ~MSK_RATE) == 8'h00))
    else $error("reserved register bits set");
  // Error answers carry no data
  read_err_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_rvalid && (s_axi_rresp == RESP_SLVERR) |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // Registers are eight bits wide, upper read bits stay zero
  read_upper_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  // Response follows one cycle after both halves are held
  write_commit_a: assert property (@(posedge clk) disable iff (rst)
    st_q.awHeld && st_q.wHeld |=> s_axi_bvalid) else $error("write not answered");
  // Readies stay low while a write response is pending
  ready_block_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
  // A pending read answer holds the read address ready low
  read_block_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_rvalid |-> !s_axi_arready) else $error("read ready early");
endmodule : sti_status_insert
`default_nettype wire

//--- tb/sti_rx_model.sv
// Purpose: Far-side receiver model watching the inserted bits
// Assumes: Audio of a sub-frame is latched on its request strobe
// Notes: Counts parity faults and sub-frames seen, never drives the block
`timescale 1ns/1ps
`default_nettype none
module sti_rx_model (
  // Clock
  input wire logic clk,
  // Request from the framer and bits sent on the line
  input wire sti_pkg::sti_sub_s subIn,
  input wire sti_pkg::sti_bits_s bitsIn,
  // Results
  output var int parErr,
  output var int subCount
);
  import sti_pkg::*;
  logic [23:0] aud;
  initial begin
    parErr = 0;
    subCount = 0;
  end
  // Audio is held until its bits arrive, a new request lands after
  always @(posedge clk) begin
    if (subIn.strobe) aud <= subIn.audio;
    if (bitsIn.strobe) begin
      subCount <= subCount + 1;
      if ((^{aud, bitsIn.valid, bitsIn.user, bitsIn.status,
          bitsIn.parity}) !== 1'b0) parErr <= parErr + 1;
    end
  end
endmodule : sti_rx_model
`default_nettype wire

//--- tb/test_sti_status_insert.sv
// Purpose: Self-checking bench for the status bit inserter
// Assumes: Registers reached over AXI4-Lite, one transfer at a time
// Notes: Status vectors are rebuilt here from the values written
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errCount++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module test_sti_status_insert;
  import sti_pkg::*;
  logic clk = 0, rst = 1;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  // Response readies stay high, so no strobe is lowered and raised at once
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  sti_sub_s subIn = '0;
  sti_rx_s rxBits = '0;
  sti_bits_s bitsOut;
  int errCount = 0, checks = 0, parErr, subCount;
  logic [23:0] aud = 24'h5A3C96;
  logic [7:0] src = 8'h97;
  logic [7:0] regIdx [6] = '{IDX_CTRL, IDX_CS1, IDX_CAT, IDX_SRC, IDX_RATE,
    IDX_WLEN};
  logic [7:0] rstV [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h0B};
  logic [7:0] wrV [6] = '{8'hF9, 8'h0E, 8'hA5, 8'h97, 8'hEA, 8'h57};
  logic [7:0] rdV [6] = '{8'h01, 8'h0E, 8'hA5, 8'h97, 8'h2A, 8'h57};

  sti_status_insert dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .subIn, .rxBits, .bitsOut);
  sti_rx_model rxModel (.clk, .subIn, .bitsIn(bitsOut), .parErr, .subCount);

  // 50 MHz clock
  always #10 clk = ~clk;

  function automatic logic [31:0] adr(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction : adr

  // Expected status bit, rebuilt from the values the bench wrote
  function automatic logic cs(input int i, input int s);
    logic [1:0] n;
    logic [39:0] v;
    n = s ? src[7:6] : src[5:4];
    v = {8'h57, 8'h2A, (n == 2'h1) ? 4'h1 : (n == 2'h2) ? 4'h2 : 4'h0,
      src[3:0], 8'hA5, 8'h0E};
    return (i < 40) ? v[i] : 1'b0;
  endfunction : cs

  // Write: both halves offered together, each dropped once taken; readies
  // are looked at mid-cycle, so the edge that follows is the taking edge
  task automatic axw(input logic [31:0] a, input logic [7:0] d);
    bit aw, w, ta, tw;
    logic [1:0] br;
    aw = 1;
    w = 1;
    br = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      @(negedge clk);
      ta = aw && s_axi_awready;
      tw = w && s_axi_wready;
      @(posedge clk);
      if (ta) begin aw = 0; s_axi_awvalid <= 0; end
      if (tw) begin w = 0; s_axi_wvalid <= 0; end
    end
    do begin
      @(negedge clk);
      ta = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge clk);
    end while (!ta);
    `CHK("bresp", RESP_OKAY, br)
  endtask : axw

  task automatic axr(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
    bit t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end while (!t);
    s_axi_arvalid <= 0;
    do begin
      @(negedge clk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
    end while (!t);
  endtask : axr

  // One sub-frame; its bits are sampled in the single strobe cycle
  task automatic sf(input logic sec, input logic bs, input logic [2:0] rx,
      input logic [2:0] ex);
    subIn <= '{1'b1, sec, bs, aud};
    rxBits <= rx;
    @(posedge clk);
    subIn.strobe <= 1'b0;
    aud <= aud + 24'h3A5C1;
    @(negedge clk);
    `CHK("bits", {1'b1, ex}, {bitsOut.strobe, bitsOut.valid, bitsOut.user,
      bitsOut.status})
    @(posedge clk);
  endtask : sf

  // One frame; md 0 own bits, 1 receiver, 2 receiver with overwrite
  task automatic fr(input int i, input bit bs, input logic [2:0] rx,
      input int md);
    logic [2:0] r, e;
    for (int s = 0; s < 2; s++) begin
      r = s ? ~rx : rx;
      e = (md == 1) ? r : {(md == 2) ? r[2:1] : 2'h0, cs(i, s)};
      sf(s[0], bs && s == 0, r, e);
    end
  endtask : fr

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Watchdog sized well past the whole sequence
  initial begin
    #400us;
    errCount++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      axr(adr(regIdx[k]), rd, rr);
      `CHK("reset value", {24'h0, rstV[k]}, rd)
    end
    axr(32'h0, rd, rr);
    `CHK("unmapped resp", RESP_SLVERR, rr)
    $display("test reset done");
    // Source select bits land at 01 from the control value written here, so bits are built locally
    for (int k = 0; k < 6; k++) axw(adr(regIdx[k]), wrV[k]);
    for (int k = 0; k < 6; k++) begin
      axr(adr(regIdx[k]), rd, rr);
      `CHK("readback", {24'h0, rdV[k]}, rd)
    end
    $display("test registers done");
    // Full block plus two frames across the wrap
    for (int i = 0; i < 194; i++) fr(i % 192, i == 0, 3'h7, 0);
    axr(adr(IDX_STAT), rd, rr);
    `CHK("frame index", 32'h2, rd)
    `CHK("parity faults", 0, parErr)
    `CHK("sub-frames", 388, subCount)
    $display("test block done");
    axw(adr(IDX_CTRL), 8'h05);
    for (int c = 0; c < 4; c++) begin
      src = {c[1:0], ~c[1:0], 4'h7};
      axw(adr(IDX_SRC), src);
      for (int i = 0; i < 24; i++) fr(i, i == 0, 3'h5, 0);
    end
    $display("test channel id done");
    axw(adr(IDX_CTRL), 8'h00);
    for (int i = 0; i < 4; i++) fr(i, i == 0, i[2:0] ^ 3'h5, 1);
    axw(adr(IDX_CTRL), 8'h04);
    for (int i = 0; i < 4; i++) fr(i, i == 0, ~i[2:0], 2);
    $display("test receiver source done");
    give_verdict();
  end
endmodule : test_sti_status_insert
`default_nettype wire
